/* File: hdl/pmbus_mfr_pkg.sv */
package pmbus_mfr_pkg;

  // Command codes of the three registers.
  localparam logic [7:0]  CMD_TARGET_ADDR      = 8'hEF;
  localparam logic [7:0]  CMD_SETTINGS_CRC     = 8'hF0;
  localparam logic [7:0]  CMD_FAULT_INJECT     = 8'hF1;

  // Bus-reserved target addresses.
  localparam logic [6:0]  RSVD_ADDR_A          = 7'h0C;
  localparam logic [6:0]  RSVD_ADDR_B          = 7'h28;
  localparam logic [6:0]  RSVD_ADDR_C          = 7'h37;
  localparam logic [6:0]  RSVD_ADDR_D          = 7'h61;

  // Address used until the strap is captured after reset.
  localparam logic [6:0]  ADDR_RESET           = 7'h00;

  // Injection register field positions.
  localparam int          FAULT_HOLD_BIT       = 15;
  localparam int          INJ_OVERTEMP_BIT     = 14;
  localparam int          INJ_OC_FAULT_BIT     = 12;
  localparam int          INJ_LOCKOUT_BIT      = 11;
  localparam int          INJ_VIN_OV_BIT       = 10;
  localparam int          INJ_VOUT_UV_BIT      = 9;
  localparam int          INJ_VOUT_OV_BIT      = 8;
  localparam int          WARN_HOLD_BIT        = 7;
  localparam int          INJ_OC_WARN_BIT      = 4;
  localparam int          INJ_VIN_UVW_BIT      = 3;
  localparam int          INJ_VOUT_UVW_BIT     = 1;
  localparam int          INJ_VOUT_OVW_BIT     = 0;

  // Field masks of the injection register.
  localparam logic [15:0] INJECT_ACTIVE_MASK   = 16'h5F1B;
  localparam logic [15:0] FAULT_AUTO_CLR_MASK  = 16'h7F00;
  localparam logic [15:0] WARN_AUTO_CLR_MASK   = 16'h007F;
  localparam logic [15:0] FAULT_FIELD_MASK     = 16'hFF00;
  localparam logic [15:0] WARN_FIELD_MASK      = 16'h00FF;
  localparam logic [15:0] IDLE_ALLOWED_MASK    = 16'h09FF;
  localparam logic [15:0] FAULT_GATED_MASK     = 16'h7600;
  localparam logic [7:0]  INJ_FAULT_RESET      = 8'h00;
  localparam logic [7:0]  INJ_WARN_RESET       = 8'h00;

  // Checksum generator.
  localparam logic [15:0] CRC_POLY             = 16'h8005;
  localparam logic [15:0] CRC_INIT             = 16'h0000;
  localparam logic [15:0] CRC_RESET            = 16'h0000;

  // Cycles after reset release before the strap and defaults are captured.
  localparam logic [1:0]  BOOT_CAPTURE_CYCLE   = 2'd2;
  localparam logic [1:0]  BOOT_DONE_CYCLE      = 2'd3;

  typedef enum logic [1:0] {
    CRC_IDLE = 2'b01,
    CRC_RUN  = 2'b10
  } crc_state_t;

endpackage

/* File: hdl/pin_sync.sv */
`timescale 1ns/1ps
module pin_sync #(
  parameter int WIDTH = 7
) (
  input  wire logic             clk_i,
  input  wire logic             rst_n_i,
  input  wire logic [WIDTH-1:0] pin_i,
  output logic      [WIDTH-1:0] sync_o
);

  logic [WIDTH-1:0] meta_r;
  logic [WIDTH-1:0] sync_r;

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      meta_r <= '0;
      sync_r <= '0;
    end else begin
      meta_r <= pin_i;
      sync_r <= meta_r;
    end
  end

  assign sync_o = sync_r;

endmodule // pin_sync

/* File: hdl/settings_crc.sv */
`timescale 1ns/1ps
module settings_crc
  import pmbus_mfr_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        rst_n_i,
  input  wire logic        start_i,
  input  wire logic        word_valid_i,
  input  wire logic [15:0] word_i,
  input  wire logic        last_i,
  output logic      [15:0] crc_o,
  output logic             busy_o
);

  crc_state_t  state_r;
  crc_state_t  state_nxt;
  logic [15:0] acc_r;
  logic [15:0] acc_nxt;
  logic [15:0] crc_r;
  logic [15:0] step;
  logic        take;
  logic        finish;

  // Word-wide MSB-first shift of the generator, one word per clock.
  function automatic logic [15:0] crc_word(input logic [15:0] c_in, input logic [15:0] d);
    logic [15:0] c;
    logic        fb;
    c = c_in;
    for (int i = 15; i >= 0; i--) begin
      fb = c[15] ^ d[i];
      c  = {c[14:0], 1'b0};
      if (fb) begin
        c = c ^ CRC_POLY;
      end
    end
    return c;
  endfunction

  assign step      = crc_word(acc_r, word_i);
  assign take      = (state_r == CRC_RUN) && word_valid_i && !start_i;
  assign finish    = take && last_i;
  assign acc_nxt   = start_i ? CRC_INIT : (take ? step : acc_r);
  assign state_nxt = start_i ? CRC_RUN : (finish ? CRC_IDLE : state_r);

  // A fresh start abandons a pass in progress, so a store during a restore still ends in a true sum.
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_r <= CRC_IDLE;
      acc_r   <= CRC_INIT;
      crc_r   <= CRC_RESET;
    end else begin
      state_r <= state_nxt;
      acc_r   <= acc_nxt;
      if (finish) begin
        crc_r <= step; // R6
      end
    end
  end

  assign crc_o  = crc_r;
  assign busy_o = state_r[1];

endmodule // settings_crc

/* File: hdl/pmbus_addr_crc_fault_inject.sv */
`timescale 1ns/1ps
// Overview of operation
// R1: A write of a valid value to the target address register takes effect as the bus address at once, no restart.
// R2: After an address change the old bus address is no longer matched, so no transaction to it is acknowledged.
// R3: The target address register holds seven address bits in 6:0 and bit 7 always reads zero.
// R4: The addresses 0x0C, 0x28, 0x37 and 0x61 are never taken as the programmed target address.
// R5: A write carrying a reserved address is dropped, the old address stays and a communication error is flagged.
// R6: The checksum is a CRC-16 with generator 0x8005 over the current non-volatile settings.
// R7: The checksum is recomputed at boot and after every store or restore of the settings.
// R8: The checksum is a read-only sixteen-bit word; a write to it is refused.
// R9: Each injection bit forces its detector output and several may be set in one write.
// R10: With bit 15 clear injected faults drop after one fault response, with it set they stay until rewritten.
// R11: With bit 7 clear injected warnings drop after one response, with it set they stay until rewritten.
// R12: Fault bits 14, 12, 11, 10, 9 and 8 reset to zero and force their faults when one.
// R13: Warning bits take their reset value from the defaults and bits 4, 3, 1 and 0 force their warnings.
// R14: Bits 13, 6, 5 and 2 are unused and never cause an injection.
// R15: Only input lockout and output overvoltage may be injected while conversion is off; the code also passes warning bits 4, 3, 1 and 0 then.
module pmbus_addr_crc_fault_inject
  import pmbus_mfr_pkg::*;
(
  input  wire logic        CLK_I,
  input  wire logic        RST_N_I,
  input  wire logic        CMD_VALID_I,
  input  wire logic        CMD_WRITE_I,
  input  wire logic [7:0]  CMD_CODE_I,
  input  wire logic [15:0] CMD_WDATA_I,
  output logic             CMD_ACK_O,
  output logic             CMD_ERR_O,
  output logic      [15:0] CMD_RDATA_O,
  input  wire logic        ADDR_QUERY_I,
  input  wire logic [6:0]  ADDR_QUERY_VALUE_I,
  output logic             ADDR_MATCH_O,
  output logic      [6:0]  TARGET_ADDR_O,
  input  wire logic [6:0]  STRAP_ADDR_I,
  input  wire logic        NVM_ADDR_LOAD_I,
  input  wire logic [6:0]  NVM_ADDR_I,
  input  wire logic [7:0]  WARN_DEFAULT_I,
  input  wire logic        NVM_CRC_START_I,
  input  wire logic        NVM_WORD_VALID_I,
  input  wire logic [15:0] NVM_WORD_I,
  input  wire logic        NVM_WORD_LAST_I,
  output logic      [15:0] SETTINGS_CRC_VALUE_O,
  output logic             CRC_BUSY_O,
  input  wire logic        CONV_ENABLE_I,
  input  wire logic        FAULT_RESPONSE_I,
  input  wire logic        WARN_RESPONSE_I,
  output logic             INJECT_OVERTEMP_FAULT_O,
  output logic             INJECT_OVERCURRENT_FAULT_O,
  output logic             INJECT_INPUT_LOCKOUT_O,
  output logic             INJECT_INPUT_OVERVOLTAGE_FAULT_O,
  output logic             INJECT_OUTPUT_UNDERVOLTAGE_FAULT_O,
  output logic             INJECT_OUTPUT_OVERVOLTAGE_FAULT_O,
  output logic             INJECT_OVERCURRENT_WARNING_O,
  output logic             INJECT_INPUT_UNDERVOLTAGE_WARNING_O,
  output logic             INJECT_OUTPUT_UNDERVOLTAGE_WARNING_O,
  output logic             INJECT_OUTPUT_OVERVOLTAGE_WARNING_O
);

  logic        rst_meta_r;
  logic        rst_sync_r;
  logic        rst_n;
  logic [6:0]  strap_addr;
  logic [1:0]  boot_cnt_r;
  logic        boot_load;
  logic [6:0]  addr_r;
  logic [6:0]  addr_nxt;
  logic [15:0] inj_r;
  logic [15:0] inj_nxt;
  logic [15:0] inj_cleared;
  logic [15:0] inj_gate;
  logic [15:0] inj_out_r;
  logic        hit_addr;
  logic        hit_crc;
  logic        hit_inj;
  logic        wr_addr;
  logic        wr_crc;
  logic        wr_inj;
  logic [6:0]  new_addr;
  logic        new_reserved;
  logic        strap_reserved;
  logic        nvm_reserved;
  logic        fault_clr;
  logic        warn_clr;
  logic        ack_nxt;
  logic        err_nxt;
  logic [15:0] rdata_nxt;
  logic        ack_r;
  logic        err_r;
  logic [15:0] rdata_r;
  logic        match_r;
  logic [15:0] crc_value;
  logic        crc_busy;

  function automatic logic addr_is_reserved(input logic [6:0] a);
    return (a == RSVD_ADDR_A) || (a == RSVD_ADDR_B) || (a == RSVD_ADDR_C) || (a == RSVD_ADDR_D);
  endfunction

  // Reset is asserted at once but released through two flops so no flop sees a partial release.
  always_ff @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      rst_meta_r <= 1'b0;
      rst_sync_r <= 1'b0;
    end else begin
      rst_meta_r <= 1'b1;
      rst_sync_r <= rst_meta_r;
    end
  end

  assign rst_n = rst_sync_r;

  pin_sync #(
    .WIDTH (7)
  ) u_strap_sync (
    .clk_i   (CLK_I),
    .rst_n_i (rst_n),
    .pin_i   (STRAP_ADDR_I),
    .sync_o  (strap_addr)
  );

  settings_crc u_settings_crc (
    .clk_i        (CLK_I),
    .rst_n_i      (rst_n),
    .start_i      (NVM_CRC_START_I), // R7
    .word_valid_i (NVM_WORD_VALID_I),
    .word_i       (NVM_WORD_I),
    .last_i       (NVM_WORD_LAST_I),
    .crc_o        (crc_value),
    .busy_o       (crc_busy)
  );

  // The strap passes two sync flops, so capture waits until they hold the pin value.
  always_ff @(posedge CLK_I or negedge rst_n) begin
    if (!rst_n) begin
      boot_cnt_r <= 2'd0;
    end else if (boot_cnt_r != BOOT_DONE_CYCLE) begin
      boot_cnt_r <= boot_cnt_r + 2'd1;
    end
  end

  assign boot_load = (boot_cnt_r == BOOT_CAPTURE_CYCLE);

  // Command decode.
  assign hit_addr       = CMD_VALID_I && (CMD_CODE_I == CMD_TARGET_ADDR);
  assign hit_crc        = CMD_VALID_I && (CMD_CODE_I == CMD_SETTINGS_CRC);
  assign hit_inj        = CMD_VALID_I && (CMD_CODE_I == CMD_FAULT_INJECT);
  assign wr_addr        = hit_addr && CMD_WRITE_I;
  assign wr_crc         = hit_crc && CMD_WRITE_I;
  assign wr_inj         = hit_inj && CMD_WRITE_I;
  assign new_addr       = CMD_WDATA_I[6:0]; // R3
  assign new_reserved   = addr_is_reserved(new_addr); // R4
  assign strap_reserved = addr_is_reserved(strap_addr); // R4
  assign nvm_reserved   = addr_is_reserved(NVM_ADDR_I); // R4

  // A host write outranks a restore load in the same cycle; a reserved value never lands.
  assign addr_nxt = (wr_addr && !new_reserved)                ? new_addr :   // R1
                    (NVM_ADDR_LOAD_I && !nvm_reserved)        ? NVM_ADDR_I :
                    (boot_load && !strap_reserved)            ? strap_addr :
                                                                addr_r;      // R5

  assign ack_nxt = hit_addr || hit_crc || hit_inj;
  assign err_nxt = (wr_addr && new_reserved) || wr_crc; // R5 R8

  assign rdata_nxt = hit_addr ? {9'h000, addr_r} :       // R3
                     hit_crc  ? crc_value :              // R8
                     hit_inj  ? inj_r :
                                16'h0000;

  // Auto-clear drops every fault or warning bit but the hold bit itself.
  assign fault_clr   = FAULT_RESPONSE_I && !inj_r[FAULT_HOLD_BIT]; // R10
  assign warn_clr    = WARN_RESPONSE_I && !inj_r[WARN_HOLD_BIT];   // R11
  assign inj_cleared = inj_r & ~({16{fault_clr}} & FAULT_AUTO_CLR_MASK)
                             & ~({16{warn_clr}} & WARN_AUTO_CLR_MASK);

  // A write in the same cycle as a response wins, so a fresh injection is never lost.
  assign inj_nxt = wr_inj    ? CMD_WDATA_I :                         // R9
                   boot_load ? {inj_cleared[15:8], WARN_DEFAULT_I} : // R13
                               inj_cleared;

  // Unused bits stay readable but are masked out of the detector paths.
  assign inj_gate = inj_r & INJECT_ACTIVE_MASK                         // R14
                  & (CONV_ENABLE_I ? 16'hFFFF : IDLE_ALLOWED_MASK);    // R15

  always_ff @(posedge CLK_I or negedge rst_n) begin
    if (!rst_n) begin
      addr_r    <= ADDR_RESET;
      inj_r     <= {INJ_FAULT_RESET, INJ_WARN_RESET}; // R12
      inj_out_r <= 16'h0000;
      ack_r     <= 1'b0;
      err_r     <= 1'b0;
      rdata_r   <= 16'h0000;
      match_r   <= 1'b0;
    end else begin
      addr_r    <= addr_nxt;
      inj_r     <= inj_nxt;
      inj_out_r <= inj_gate; // R9
      ack_r     <= ack_nxt;
      err_r     <= err_nxt;
      if (hit_addr || hit_crc || hit_inj) begin
        rdata_r <= rdata_nxt;
      end
      match_r   <= ADDR_QUERY_I && (ADDR_QUERY_VALUE_I == addr_r); // R2
    end
  end

  assign CMD_ACK_O                            = ack_r;
  assign CMD_ERR_O                            = err_r;
  assign CMD_RDATA_O                          = rdata_r;
  assign ADDR_MATCH_O                         = match_r;
  assign TARGET_ADDR_O                        = addr_r;
  assign SETTINGS_CRC_VALUE_O                 = crc_value;
  assign CRC_BUSY_O                           = crc_busy;
  assign INJECT_OVERTEMP_FAULT_O              = inj_out_r[INJ_OVERTEMP_BIT];
  assign INJECT_OVERCURRENT_FAULT_O           = inj_out_r[INJ_OC_FAULT_BIT];
  assign INJECT_INPUT_LOCKOUT_O               = inj_out_r[INJ_LOCKOUT_BIT];
  assign INJECT_INPUT_OVERVOLTAGE_FAULT_O     = inj_out_r[INJ_VIN_OV_BIT];
  assign INJECT_OUTPUT_UNDERVOLTAGE_FAULT_O   = inj_out_r[INJ_VOUT_UV_BIT];
  assign INJECT_OUTPUT_OVERVOLTAGE_FAULT_O    = inj_out_r[INJ_VOUT_OV_BIT];
  assign INJECT_OVERCURRENT_WARNING_O         = inj_out_r[INJ_OC_WARN_BIT];
  assign INJECT_INPUT_UNDERVOLTAGE_WARNING_O  = inj_out_r[INJ_VIN_UVW_BIT];
  assign INJECT_OUTPUT_UNDERVOLTAGE_WARNING_O = inj_out_r[INJ_VOUT_UVW_BIT];
  assign INJECT_OUTPUT_OVERVOLTAGE_WARNING_O  = inj_out_r[INJ_VOUT_OVW_BIT];

  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (!rst_n);

  property p_new_addr;
    wr_addr && !new_reserved |=> TARGET_ADDR_O == $past(new_addr) ##1 1'b1;
  endproperty
  a_new_addr: assert property (p_new_addr) else $error("valid address write not adopted"); // R1

  property p_old_addr_nack;
    (wr_addr && !new_reserved && (new_addr != addr_r)) ##1 (!wr_addr && !NVM_ADDR_LOAD_I && !boot_load) ##1
      (ADDR_QUERY_I && (ADDR_QUERY_VALUE_I == $past(addr_r, 2))) |=> !ADDR_MATCH_O;
  endproperty
  a_old_addr_nack: assert property (p_old_addr_nack) else $error("old address still matched"); // R2

  property p_addr_bit7_zero;
    hit_addr && !CMD_WRITE_I |=> CMD_ACK_O && (CMD_RDATA_O[15:7] == 9'h000);
  endproperty
  a_addr_bit7_zero: assert property (p_addr_bit7_zero) else $error("address readback high bits not zero"); // R3

  property p_reserved_kept;
    wr_addr && new_reserved && !NVM_ADDR_LOAD_I && !boot_load |=> CMD_ERR_O && $stable(TARGET_ADDR_O);
  endproperty
  a_reserved_kept: assert property (p_reserved_kept) else $error("reserved address accepted"); // R4 R5

  property p_crc_read_only;
    wr_crc && !crc_busy && !NVM_CRC_START_I |=> CMD_ERR_O && $stable(SETTINGS_CRC_VALUE_O);
  endproperty
  a_crc_read_only: assert property (p_crc_read_only) else $error("checksum write not refused"); // R8

  property p_fault_auto_clear;
    fault_clr && !wr_inj |=> (inj_r & FAULT_AUTO_CLR_MASK) == 16'h0000 ##1 (inj_out_r & FAULT_GATED_MASK) == 16'h0000;
  endproperty
  a_fault_auto_clear: assert property (p_fault_auto_clear) else $error("fault injection not cleared"); // R10

  property p_fault_hold;
    inj_r[FAULT_HOLD_BIT] && !wr_inj |=> (inj_r & FAULT_FIELD_MASK) == ($past(inj_r) & FAULT_FIELD_MASK);
  endproperty
  a_fault_hold: assert property (p_fault_hold) else $error("held fault injection changed"); // R10

  property p_warn_clear_or_hold;
    WARN_RESPONSE_I && !wr_inj && !boot_load |=>
      (inj_r & WARN_AUTO_CLR_MASK) == ($past(inj_r[WARN_HOLD_BIT]) ? ($past(inj_r) & WARN_AUTO_CLR_MASK) : 16'h0000);
  endproperty
  a_warn_clear_or_hold: assert property (p_warn_clear_or_hold) else $error("warning injection wrong after response"); // R11

  property p_inject_path;
    wr_inj && CONV_ENABLE_I ##1 (CONV_ENABLE_I && !wr_inj && !FAULT_RESPONSE_I && !WARN_RESPONSE_I)
      |=> inj_out_r == ($past(CMD_WDATA_I, 2) & INJECT_ACTIVE_MASK);
  endproperty
  a_inject_path: assert property (p_inject_path) else $error("injection outputs differ from write"); // R9 R12 R13 R14

  property p_idle_gate;
    !CONV_ENABLE_I |=> (inj_out_r & FAULT_GATED_MASK) == 16'h0000;
  endproperty
  a_idle_gate: assert property (p_idle_gate) else $error("fault injected while conversion off"); // R15

  // Lockout and output overvoltage must still reach their detectors with conversion off.
  property p_idle_allowed;
    !CONV_ENABLE_I |=> (INJECT_INPUT_LOCKOUT_O == $past(inj_r[INJ_LOCKOUT_BIT]))
                    && (INJECT_OUTPUT_OVERVOLTAGE_FAULT_O == $past(inj_r[INJ_VOUT_OV_BIT]));
  endproperty
  a_idle_allowed: assert property (p_idle_allowed) else $error("permitted idle injection blocked"); // R15

  property p_unused_no_inject;
    wr_inj && ((CMD_WDATA_I & INJECT_ACTIVE_MASK) == 16'h0000) ##1 !wr_inj |=> inj_out_r == 16'h0000;
  endproperty
  a_unused_no_inject: assert property (p_unused_no_inject) else $error("unused bit caused injection"); // R14

  property p_crc_done;
    crc_busy && NVM_WORD_VALID_I && NVM_WORD_LAST_I && !NVM_CRC_START_I |=> !CRC_BUSY_O;
  endproperty
  a_crc_done: assert property (p_crc_done) else $error("checksum pass did not end on last word"); // R7

  // The host must never see the checksum move outside a pass.
  property p_crc_steady;
    !crc_busy |=> $stable(SETTINGS_CRC_VALUE_O);
  endproperty
  a_crc_steady: assert property (p_crc_steady) else $error("checksum changed while idle"); // R8

  property p_match_current;
    ADDR_QUERY_I |=> ADDR_MATCH_O == ($past(ADDR_QUERY_VALUE_I) == $past(addr_r));
  endproperty
  a_match_current: assert property (p_match_current) else $error("address match wrong"); // R1 R2

endmodule // pmbus_addr_crc_fault_inject

/* File: verification/host_ctrl_model.sv */
`timescale 1ns/1ps
module host_ctrl_model (
  input  wire logic        clk_i,
  output logic             cmd_valid_o,
  output logic             cmd_write_o,
  output logic      [7:0]  cmd_code_o,
  output logic      [15:0] cmd_wdata_o,
  input  wire logic        cmd_ack_i,
  input  wire logic        cmd_err_i,
  input  wire logic [15:0] cmd_rdata_i,
  output logic             query_o,
  output logic      [6:0]  query_value_o,
  input  wire logic        match_i
);
  initial begin
    cmd_valid_o = 1'b0;
    cmd_write_o = 1'b0;
    cmd_code_o = 8'h00;
    cmd_wdata_o = 16'h0000;
    query_o = 1'b0;
    query_value_o = 7'h00;
  end

  // Released lines are flipped so a stale value never passes for fresh data, and an idle
  // cycle follows each request so back-to-back calls never rewrite the strobe in one step.
  task automatic command(input logic w, input logic [7:0] c, input logic [15:0] d,
                         output logic ack, output logic err, output logic [15:0] rd);
    cmd_valid_o = 1'b1;
    cmd_write_o = w;
    cmd_code_o = c;
    cmd_wdata_o = d;
    @(posedge clk_i);
    #1;
    ack = cmd_ack_i;
    err = cmd_err_i;
    rd = cmd_rdata_i;
    cmd_valid_o = 1'b0;
    cmd_code_o = ~c;
    cmd_wdata_o = ~d;
    @(posedge clk_i);
    #1;
  endtask

  // The controller acknowledges an address byte only when the device reports a match.
  task automatic query(input logic [6:0] v, output logic m);
    query_o = 1'b1;
    query_value_o = v;
    @(posedge clk_i);
    #1;
    m = match_i;
    query_o = 1'b0;
    query_value_o = ~v;
    @(posedge clk_i);
    #1;
  endtask
endmodule // host_ctrl_model

/* File: verification/tb.sv */
`timescale 1ns/1ps
module tb;
  import pmbus_mfr_pkg::*;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        valid, wr, ack, err, query, match, busy;
  logic        crc_start = 1'b0;
  logic        word_valid = 1'b0;
  logic        word_last = 1'b0;
  logic        conv = 1'b0;
  logic        fresp = 1'b0;
  logic        wresp = 1'b0;
  logic        nvm_load = 1'b0;
  logic [6:0]  nvm_addr = 7'h00;
  logic [7:0]  code;
  logic [15:0] wdata, rdata, crc_val, inj_reg, last_crc;
  logic [15:0] word = 16'h0000;
  logic [6:0]  qval, taddr, cur_addr;
  logic [6:0]  strap = 7'h5A;
  logic [7:0]  warn_def = 8'h9B;
  logic [6:0]  rsv [4] = '{7'h0C, 7'h28, 7'h37, 7'h61};
  wire  [15:0] inj_v;
  int          bad_count = 0;
  int          cmp_count = 0;

  always #2.5 clk = ~clk;
  assign {inj_v[15], inj_v[13], inj_v[7:5], inj_v[2]} = 6'h00;

  host_ctrl_model u_host_ctrl_model (
    .clk_i(clk), .cmd_valid_o(valid), .cmd_write_o(wr), .cmd_code_o(code), .cmd_wdata_o(wdata),
    .cmd_ack_i(ack), .cmd_err_i(err), .cmd_rdata_i(rdata), .query_o(query), .query_value_o(qval),
    .match_i(match)
  );

  pmbus_addr_crc_fault_inject u_pmbus_addr_crc_fault_inject (
    .CLK_I(clk), .RST_N_I(rst_n), .CMD_VALID_I(valid), .CMD_WRITE_I(wr), .CMD_CODE_I(code),
    .CMD_WDATA_I(wdata), .CMD_ACK_O(ack), .CMD_ERR_O(err), .CMD_RDATA_O(rdata),
    .ADDR_QUERY_I(query), .ADDR_QUERY_VALUE_I(qval), .ADDR_MATCH_O(match), .TARGET_ADDR_O(taddr),
    .STRAP_ADDR_I(strap), .NVM_ADDR_LOAD_I(nvm_load), .NVM_ADDR_I(nvm_addr), .WARN_DEFAULT_I(warn_def),
    .NVM_CRC_START_I(crc_start), .NVM_WORD_VALID_I(word_valid), .NVM_WORD_I(word),
    .NVM_WORD_LAST_I(word_last), .SETTINGS_CRC_VALUE_O(crc_val), .CRC_BUSY_O(busy),
    .CONV_ENABLE_I(conv), .FAULT_RESPONSE_I(fresp), .WARN_RESPONSE_I(wresp),
    .INJECT_OVERTEMP_FAULT_O(inj_v[14]), .INJECT_OVERCURRENT_FAULT_O(inj_v[12]),
    .INJECT_INPUT_LOCKOUT_O(inj_v[11]), .INJECT_INPUT_OVERVOLTAGE_FAULT_O(inj_v[10]),
    .INJECT_OUTPUT_UNDERVOLTAGE_FAULT_O(inj_v[9]), .INJECT_OUTPUT_OVERVOLTAGE_FAULT_O(inj_v[8]),
    .INJECT_OVERCURRENT_WARNING_O(inj_v[4]), .INJECT_INPUT_UNDERVOLTAGE_WARNING_O(inj_v[3]),
    .INJECT_OUTPUT_UNDERVOLTAGE_WARNING_O(inj_v[1]), .INJECT_OUTPUT_OVERVOLTAGE_WARNING_O(inj_v[0])
  );

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("Error at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask

  task automatic results();
    $display("Comparisons %0d, mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  task automatic tick();
    @(posedge clk);
    #1;
  endtask

  task automatic cmd(input logic w, input logic [7:0] c, input logic [15:0] d, input logic e_exp,
                     output logic [15:0] rd);
    logic a;
    logic e;
    u_host_ctrl_model.command(w, c, d, a, e, rd);
    check({15'h0000, a}, 16'h0001);
    check({15'h0000, e}, {15'h0000, e_exp});
  endtask

  task automatic probe(input logic [6:0] v, input logic exp);
    logic m;
    u_host_ctrl_model.query(v, m);
    check({15'h0000, m}, {15'h0000, exp});
  endtask

  // Reference checksum: MSB first, zero start value, no reflection and no final inversion.
  task automatic crc_pass(input int n);
    logic [15:0] q[$];
    logic [15:0] rd;
    int          i;
    last_crc = 16'h0000;
    for (i = 0; i < n; i++) begin
      q.push_back(16'($urandom));
      for (int b = 15; b >= 0; b--) begin
        last_crc = {last_crc[14:0], 1'b0} ^ ((last_crc[15] ^ q[i][b]) ? 16'h8005 : 16'h0000);
      end
    end
    crc_start = 1'b1;
    tick();
    crc_start = 1'b0;
    check({15'h0000, busy}, 16'h0001);
    foreach (q[k]) begin
      word_valid = 1'b1;
      word = q[k];
      word_last = (k == n - 1);
      tick();
    end
    word_valid = 1'b0;
    word_last = 1'b0;
    word = ~word;
    for (i = 0; i < 8 && busy !== 1'b0; i++) tick();
    if (i == 8) begin
      bad_count++;
      $display("Error at %0t: checksum pass never finished", $time);
      results();
    end
    check(crc_val, last_crc);
    cmd(1'b0, CMD_SETTINGS_CRC, 16'h0000, 1'b0, rd);
    check(rd, last_crc);
  endtask

  task automatic inj_check();
    check(inj_v, inj_reg & 16'h5F1B & (conv ? 16'hFFFF : 16'h09FF));
  endtask

  initial begin
    logic [15:0] rd;
    logic [6:0]  a;
    logic        ua;
    logic        ue;
    int          i;
    void'($urandom(16962));
    repeat (2) @(posedge clk);
    #1;
    rst_n = 1'b1;
    repeat (12) tick();
    cmd(1'b0, CMD_TARGET_ADDR, 16'h0000, 1'b0, rd);
    check(rd, {9'h000, strap});
    cmd(1'b0, CMD_FAULT_INJECT, 16'h0000, 1'b0, rd);
    check(rd, {8'h00, warn_def});
    crc_pass(3);
    $display("Test boot done");
    cur_addr = strap;
    for (i = 0; i < 6; i++) begin
      do a = 7'($urandom); while (a inside {7'h0C, 7'h28, 7'h37, 7'h61} || a == cur_addr);
      cmd(1'b1, CMD_TARGET_ADDR, {9'($urandom), a}, 1'b0, rd);
      probe(cur_addr, 1'b0);
      probe(a, 1'b1);
      check({9'h000, taddr}, {9'h000, a});
      cmd(1'b0, CMD_TARGET_ADDR, 16'h0000, 1'b0, rd);
      check(rd, {9'h000, a});
      cur_addr = a;
    end
    foreach (rsv[k]) begin
      cmd(1'b1, CMD_TARGET_ADDR, {9'h000, rsv[k]}, 1'b1, rd);
      probe(rsv[k], 1'b0);
      probe(cur_addr, 1'b1);
    end
    u_host_ctrl_model.command(1'b1, 8'hEE, 16'($urandom), ua, ue, rd);
    check({14'h0000, ua, ue}, 16'h0000);
    nvm_addr = rsv[2];
    nvm_load = 1'b1;
    tick();
    nvm_load = 1'b0;
    check({9'h000, taddr}, {9'h000, cur_addr});
    do a = 7'($urandom); while (a inside {7'h0C, 7'h28, 7'h37, 7'h61} || a == cur_addr);
    nvm_addr = a;
    nvm_load = 1'b1;
    tick();
    nvm_load = 1'b0;
    probe(cur_addr, 1'b0);
    probe(a, 1'b1);
    cur_addr = a;
    $display("Test address done");
    crc_pass(1);
    crc_pass(16);
    cmd(1'b1, CMD_SETTINGS_CRC, 16'($urandom), 1'b1, rd);
    cmd(1'b0, CMD_SETTINGS_CRC, 16'h0000, 1'b0, rd);
    check(rd, last_crc);
    $display("Test checksum done");
    for (i = 0; i < 16; i++) begin
      conv = 1'($urandom);
      inj_reg = 16'($urandom);
      cmd(1'b1, CMD_FAULT_INJECT, inj_reg, 1'b0, rd);
      inj_check();
      cmd(1'b0, CMD_FAULT_INJECT, 16'h0000, 1'b0, rd);
      check(rd, inj_reg);
      fresp = 1'b1;
      tick();
      fresp = 1'b0;
      if (!inj_reg[15]) inj_reg = inj_reg & 16'h80FF;
      tick();
      inj_check();
      wresp = 1'b1;
      tick();
      wresp = 1'b0;
      if (!inj_reg[7]) inj_reg = inj_reg & 16'hFF80;
      tick();
      inj_check();
    end
    inj_reg = 16'hA0E4;
    cmd(1'b1, CMD_FAULT_INJECT, inj_reg, 1'b0, rd);
    inj_check();
    tick();
    $display("Test injection done");
    results();
  end
endmodule // tb
